// [verilog/cdc_consts.vh]
`ifndef CDC_CONSTS_VH
`define CDC_CONSTS_VH
// byte addresses: four times the register index
`define CDC_OFF_DAC_CTRL    14'h2438
`define CDC_OFF_DAC_LEVEL   14'h243c
`define CDC_OFF_CMP_MIRROR  14'h263c
`define CDC_OFF_CMPA_1      14'h2640
`define CDC_OFF_CMPB_1      14'h2644
`define CDC_OFF_CMPA_2      14'h2650
`define CDC_OFF_CMPB_2      14'h2654
// register indices
`define CDC_IDX_DAC_CTRL    12'h90e
`define CDC_IDX_DAC_LEVEL   12'h90f
`define CDC_IDX_CMP_MIRROR  12'h98f
`define CDC_IDX_CMPA_1      12'h990
`define CDC_IDX_CMPB_1      12'h991
`define CDC_IDX_CMPA_2      12'h994
`define CDC_IDX_CMPB_2      12'h995
// dac control field positions
`define CDC_DAC_EN_BIT      7
`define CDC_DAC_OE_BIT      5
`define CDC_DAC_PSS_HI      3
`define CDC_DAC_PSS_LO      2
`define CDC_DAC_NSS_BIT     0
`define CDC_DAC_CTRL_MASK   8'had
`define CDC_DAC_LEVEL_MASK  8'h1f
// positive source codes
`define CDC_PSS_SUPPLY      2'h0
`define CDC_PSS_EXTREF      2'h1
`define CDC_PSS_FIXEDREF    2'h2
`define CDC_PSS_RESERVED    2'h3
// comparator control a field positions
`define CDC_CMP_EN_BIT      7
`define CDC_CMP_OUT_BIT     6
`define CDC_CMP_POL_BIT     4
`define CDC_CMP_HYS_BIT     1
`define CDC_CMP_SYNC_BIT    0
`define CDC_CMPA_MASK       8'h93
// comparator control b field positions
`define CDC_CMP_INTP_BIT    1
`define CDC_CMP_INTN_BIT    0
`define CDC_CMPB_MASK       8'h03
`define CDC_RESET_BYTE      8'h00
`define CDC_CYCLE_DIV       2'h3
`endif

// [verilog/cdc_comparator_dac_control.v]
`timescale 1ns/1ps
`include "cdc_consts.vh"
module cdc_comparator_dac_control (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hsel,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [1:0]  cmpRaw,
  input  wire        gateClk,
  input  wire        refPinIn,
  input  wire [1:0]  pinRouteSel,
  input  wire [1:0]  pinDirection,
  input  wire        irqFlagClear,
  output reg         dacEnable,
  output reg  [4:0]  dacLevelCode,
  output reg  [2:0]  dacPosSource,
  output reg         dacNegExtRef,
  output reg         dacPinDriveEnable,
  output reg         refPinReadValue,
  output reg         refPinDigitalOff,
  output reg  [1:0]  cmpInputsOn,
  output reg  [1:0]  cmpHysteresis,
  output reg  [1:0]  cmpGate,
  output reg  [1:0]  cmpPinOut,
  output reg  [1:0]  cmpPinOe,
  output reg  [1:0]  cmpIrqFlag
);

  reg  [7:0]  dacCtrl;
  reg  [7:0]  dacLevel;
  reg  [7:0]  cmpA [0:1];
  reg  [7:0]  cmpB [0:1];
  reg         addrValid;
  reg         addrWrite;
  reg  [13:0] addrReg;
  reg  [1:0]  rawMeta;
  reg  [1:0]  rawSync;
  reg  [1:0]  cycleCnt;
  reg  [1:0]  cmpLatched;
  reg  [1:0]  prevOut;
  reg  [1:0]  gateSync1;
  reg  [1:0]  gateSync2;
  reg  [1:0]  gateCapMeta;
  reg  [1:0]  gateCapSync;
  reg         pinMeta;
  reg         pinSync;
  reg         clrMeta;
  reg         clrSync;
  reg  [1:0]  cmpFalling;
  wire [1:0]  next_out;
  wire [1:0]  riseEv;
  wire [1:0]  fallEv;
  reg  [31:0] next_rdata;
  wire        addrPhase;
  wire        wrEnable;
  wire [13:0] wrAddr;
  wire        wrDacCtrl;
  wire        wrDacLevel;
  wire [1:0]  wrCmpA;
  wire [1:0]  wrCmpB;
  integer     i;
  integer     k;
  genvar      g;

  assign addrPhase = hsel & hready & htrans[1];

  // write strobes, decoded from the captured address phase
  assign wrEnable   = addrValid & addrWrite;
  assign wrAddr     = {addrReg[13:2], 2'b00};
  assign wrDacCtrl  = wrEnable & (wrAddr == `CDC_OFF_DAC_CTRL);
  assign wrDacLevel = wrEnable & (wrAddr == `CDC_OFF_DAC_LEVEL);
  assign wrCmpA[0]  = wrEnable & (wrAddr == `CDC_OFF_CMPA_1);
  assign wrCmpA[1]  = wrEnable & (wrAddr == `CDC_OFF_CMPA_2);
  assign wrCmpB[0]  = wrEnable & (wrAddr == `CDC_OFF_CMPB_1);
  assign wrCmpB[1]  = wrEnable & (wrAddr == `CDC_OFF_CMPB_2);

  // AHB-Lite slave: zero wait states, always OKAY
  always @(posedge clk) begin
    if (!rst_n) begin
      addrValid <= 1'b0;
      addrWrite <= 1'b0;
      addrReg   <= 14'h0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        addrValid <= addrPhase;
        addrWrite <= hwrite;
        addrReg   <= haddr[13:0];
      end
      if (addrPhase && !hwrite)
        hrdata <= next_rdata;
    end
  end

  // read mux, unmapped addresses read zero
  always @* begin
    next_rdata = 32'h00000000;
    case ({haddr[13:2], 2'b00})
      `CDC_OFF_DAC_CTRL:   next_rdata[7:0] = dacCtrl;
      `CDC_OFF_DAC_LEVEL:  next_rdata[7:0] = dacLevel;
      `CDC_OFF_CMP_MIRROR: next_rdata[1:0] = cmpLatched;
      `CDC_OFF_CMPA_1:     next_rdata[7:0] = cmpA[0] |
        ({7'h00, cmpLatched[0]} << `CDC_CMP_OUT_BIT);
      `CDC_OFF_CMPB_1:     next_rdata[7:0] = cmpB[0];
      `CDC_OFF_CMPA_2:     next_rdata[7:0] = cmpA[1] |
        ({7'h00, cmpLatched[1]} << `CDC_CMP_OUT_BIT);
      `CDC_OFF_CMPB_2:     next_rdata[7:0] = cmpB[1];
      default:             next_rdata = 32'h00000000;
    endcase
  end

  // register writes; only reset clears them, sleep has no effect
  always @(posedge clk) begin
    if (!rst_n) begin
      dacCtrl  <= `CDC_RESET_BYTE;
      dacLevel <= `CDC_RESET_BYTE;
      for (i = 0; i < 2; i = i + 1) begin
        cmpA[i] <= `CDC_RESET_BYTE;
        cmpB[i] <= `CDC_RESET_BYTE;
      end
    end else begin
      if (wrDacCtrl)
        dacCtrl <= hwdata[7:0] & `CDC_DAC_CTRL_MASK;
      if (wrDacLevel)
        dacLevel <= hwdata[7:0] & `CDC_DAC_LEVEL_MASK;
      for (i = 0; i < 2; i = i + 1) begin
        if (wrCmpA[i])
          cmpA[i] <= hwdata[7:0] & `CDC_CMPA_MASK;
        if (wrCmpB[i])
          cmpB[i] <= hwdata[7:0] & `CDC_CMPB_MASK;
      end
    end
  end

  // dac analog controls
  always @(posedge clk) begin
    if (!rst_n) begin
      dacEnable         <= 1'b0;
      dacLevelCode      <= 5'h00;
      dacPosSource      <= 3'h0;
      dacNegExtRef      <= 1'b0;
    end else begin
      dacEnable    <= dacCtrl[`CDC_DAC_EN_BIT];
      dacLevelCode <= dacLevel[4:0];
      // one-hot source select, reserved code selects nothing
      case (dacCtrl[`CDC_DAC_PSS_HI:`CDC_DAC_PSS_LO])
        `CDC_PSS_SUPPLY:   dacPosSource <= 3'h1;
        `CDC_PSS_EXTREF:   dacPosSource <= 3'h2;
        `CDC_PSS_FIXEDREF: dacPosSource <= 3'h4;
        default:           dacPosSource <= 3'h0;
      endcase
      dacNegExtRef <= dacCtrl[`CDC_DAC_NSS_BIT];
    end
  end

  // reference pin override and read gating
  always @(posedge clk) begin
    if (!rst_n) begin
      dacPinDriveEnable <= 1'b0;
      refPinDigitalOff  <= 1'b0;
      refPinReadValue   <= 1'b0;
    end else begin
      // single pin destination, so one-hot holds trivially
      dacPinDriveEnable <= dacCtrl[`CDC_DAC_OE_BIT];
      refPinDigitalOff  <= dacCtrl[`CDC_DAC_OE_BIT];
      refPinReadValue   <= dacCtrl[`CDC_DAC_OE_BIT] ? 1'b0 : pinSync;
    end
  end

  // comparator decisions, two stages before any logic
  always @(posedge clk) begin
    if (!rst_n) begin
      rawMeta <= 2'h0;
      rawSync <= 2'h0;
    end else begin
      rawMeta <= cmpRaw;
      rawSync <= rawMeta;
    end
  end

  // reference pin level and flag clear request
  always @(posedge clk) begin
    if (!rst_n) begin
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
      clrMeta <= 1'b0;
      clrSync <= 1'b0;
    end else begin
      pinMeta <= refPinIn;
      pinSync <= pinMeta;
      clrMeta <= irqFlagClear;
      clrSync <= clrMeta;
    end
  end

  // per-comparator output: enable gate then polarity
  generate
    for (g = 0; g < 2; g = g + 1) begin : gCmpOut
      // raw is high when plus above minus
      assign next_out[g] = (rawSync[g] & cmpA[g][`CDC_CMP_EN_BIT]) ^
                           cmpA[g][`CDC_CMP_POL_BIT];
      assign riseEv[g]   = next_out[g] & ~prevOut[g] &
                           cmpB[g][`CDC_CMP_INTP_BIT];
      assign fallEv[g]   = ~next_out[g] & prevOut[g] &
                           cmpB[g][`CDC_CMP_INTN_BIT];
    end
  endgenerate

  // latch on the gating clock's falling edge, after any prescaler
  always @(negedge gateClk) begin
    cmpFalling <= cmpLatched;
  end

  // gate-domain latch back into clk, bit by bit
  always @(posedge clk) begin
    if (!rst_n) begin
      gateCapMeta <= 2'h0;
      gateCapSync <= 2'h0;
      gateSync1   <= 2'h0;
      gateSync2   <= 2'h0;
    end else begin
      gateCapMeta <= cmpFalling;
      gateCapSync <= gateCapMeta;
      gateSync1   <= gateCapSync;
      gateSync2   <= gateSync1;
    end
  end

  // instruction-cycle latch of the internal result
  always @(posedge clk) begin
    if (!rst_n) begin
      cycleCnt   <= 2'h0;
      cmpLatched <= 2'h0;
      prevOut    <= 2'h0;
    end else begin
      cycleCnt <= cycleCnt + 2'h1;
      if (cycleCnt == `CDC_CYCLE_DIV)
        cmpLatched <= next_out;
      prevOut <= next_out;
    end
  end

  // edge interrupts, an edge wins over a concurrent clear
  always @(posedge clk) begin
    if (!rst_n) begin
      cmpIrqFlag <= 2'h0;
    end else begin
      cmpIrqFlag <= riseEv | fallEv |
                    (cmpIrqFlag & ~{2{clrSync}});
    end
  end

  // analog controls, gate source and pin routing
  always @(posedge clk) begin
    if (!rst_n) begin
      cmpInputsOn   <= 2'h0;
      cmpHysteresis <= 2'h0;
      cmpGate       <= 2'h0;
      cmpPinOut     <= 2'h0;
      cmpPinOe      <= 2'h0;
    end else begin
      for (k = 0; k < 2; k = k + 1) begin
        cmpInputsOn[k]   <= cmpA[k][`CDC_CMP_EN_BIT];
        cmpHysteresis[k] <= cmpA[k][`CDC_CMP_HYS_BIT];
        // synced gate only meaningful on the first timer's clock
        cmpGate[k] <= cmpA[k][`CDC_CMP_SYNC_BIT] ? gateSync2[k]
                                                  : cmpLatched[k];
        cmpPinOut[k] <= next_out[k]; // unlatched external output
        cmpPinOe[k]  <= pinRouteSel[k] & ~pinDirection[k];
      end
    end
  end

endmodule // cdc_comparator_dac_control

// [testbench/cdc_partner.sv]
`timescale 1ns/1ps
module cdc_partner (
  input  wire [1:0] want,
  output logic [1:0] cmpRaw,
  output logic       gateClk,
  output logic       refPinIn
);
  initial begin
    cmpRaw = 2'h0;
    gateClk = 1'b0;
    refPinIn = 1'b0;
  end
  // first timer clock, free running
  always #170 gateClk = ~gateClk;
  always #410 refPinIn = ~refPinIn;
  // decision settles out of phase with clk
  always @(want) cmpRaw <= #($urandom_range(5, 60)) want;
endmodule // cdc_partner

// [testbench/cdc_chk.sv]
`timescale 1ns/1ps
module cdc_chk (
  input wire       clk,
  input wire       rst_n,
  input wire       dacEnable,
  input wire [4:0] dacLevelCode,
  input wire [2:0] dacPosSource,
  input wire       dacPinDriveEnable,
  input wire       refPinReadValue,
  input wire       refPinDigitalOff,
  input wire       refPinIn,
  input wire [1:0] pinRouteSel,
  input wire [1:0] pinDirection,
  input wire [1:0] cmpPinOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence quietPin;
    ($stable(refPinIn) && $stable(dacPinDriveEnable)) [*6];
  endsequence
  sequence routeOn(i);
    (pinRouteSel[i] && !pinDirection[i]) [*2];
  endsequence
  reset_clear_a: assert property ($rose(rst_n) |-> !dacEnable &&
    dacLevelCode == 5'h00 && !dacPinDriveEnable) else $error("dac not reset");
  src_onehot_a: assert property ($onehot0(dacPosSource))
    else $error("source not one-hot");
  pin_zero_a: assert property (dacPinDriveEnable |-> !refPinReadValue)
    else $error("pin read not zero");
  pin_override_a: assert property (dacPinDriveEnable |->
    refPinDigitalOff) else $error("pin buffer not overridden");
  pin_echo_a: assert property (quietPin |-> refPinReadValue ==
    (refPinIn && !dacPinDriveEnable)) else $error("pin read wrong");
  route_on_a: assert property (routeOn(0) |-> cmpPinOe[0])
    else $error("pin not driven");
  route_off_a: assert property ((!pinRouteSel[0] || pinDirection[0]) [*2]
    |-> !cmpPinOe[0]) else $error("pin driven");
  route_two_a: assert property (routeOn(1) |-> cmpPinOe[1])
    else $error("second pin not driven");
endmodule // cdc_chk

// [testbench/testbench.sv]
`timescale 1ns/1ps
`include "cdc_consts.vh"
module testbench;
  logic        clk, rst_n, hwrite, irqFlagClear;
  logic [31:0] haddr, hwdata, rd, v, e, base;
  logic [1:0]  htrans, want, pinRouteSel, pinDirection;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, gateClk, refPinIn, dacEnable, dacNegExtRef;
  wire         dacPinDriveEnable, refPinReadValue, refPinDigitalOff;
  wire  [4:0]  dacLevelCode;
  wire  [2:0]  dacPosSource;
  wire  [1:0]  cmpRaw, cmpInputsOn, cmpHysteresis, cmpGate, cmpPinOut;
  wire  [1:0]  cmpPinOe, cmpIrqFlag;
  int          errors, total_checks, i, c, p, r;
  logic [31:0] expQ[$], obsQ[$];
  cdc_comparator_dac_control u_dut (.clk(clk), .rst_n(rst_n),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmpRaw(cmpRaw),
    .gateClk(gateClk), .refPinIn(refPinIn), .pinRouteSel(pinRouteSel),
    .pinDirection(pinDirection), .irqFlagClear(irqFlagClear),
    .dacEnable(dacEnable), .dacLevelCode(dacLevelCode),
    .dacPosSource(dacPosSource), .dacNegExtRef(dacNegExtRef),
    .dacPinDriveEnable(dacPinDriveEnable), .cmpGate(cmpGate),
    .refPinReadValue(refPinReadValue), .refPinDigitalOff(refPinDigitalOff),
    .cmpInputsOn(cmpInputsOn), .cmpHysteresis(cmpHysteresis),
    .cmpPinOut(cmpPinOut), .cmpPinOe(cmpPinOe), .cmpIrqFlag(cmpIrqFlag));
  cdc_partner u_partner (.want(want), .cmpRaw(cmpRaw), .gateClk(gateClk),
    .refPinIn(refPinIn));
  always #25 clk = ~clk;
  task automatic bus(input logic w, input logic [31:0] a, d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] x, g);
    expQ.push_back(x);
    obsQ.push_back(g);
  endtask
  task automatic rdchk(input logic [31:0] a, x);
    bus(1'b0, a, 32'h0);
    chk(x, rd);
    chk(hresp, 0);
  endtask
  task automatic note(input string s);
    @(posedge clk);
    $display("test %s done", s);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) while (obsQ.size() > 0) begin
    total_checks++;
    if (obsQ.pop_front() !== expQ.pop_front()) begin
      errors++;
      $display("mismatch at %0t: value differs", $time);
    end
  end
  initial begin
    #1000000;
    errors++;
    test_done;
  end
  initial begin
    {clk, rst_n, hwrite, irqFlagClear, haddr, hwdata, htrans} = '0;
    {want, pinRouteSel, pinDirection} = '0;
    void'($urandom(32'h427d));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(`CDC_OFF_DAC_CTRL, 0);
    rdchk(`CDC_OFF_DAC_LEVEL, 0);
    rdchk(32'h0, 0);
    note("reset");
    for (i = 0; i < 4; i++) begin
      bus(1'b1, `CDC_OFF_DAC_CTRL, 8'ha1 | i << 2);
      repeat (2) @(posedge clk);
      rdchk(`CDC_OFF_DAC_CTRL, 8'ha1 | i << 2);
      chk({dacEnable, dacPinDriveEnable, dacNegExtRef, refPinReadValue}, 4'he);
      chk(dacPosSource, i == 3 ? 0 : 1 << i);
    end
    for (i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'hff : $urandom_range(0, 255);
      bus(1'b1, `CDC_OFF_DAC_LEVEL, v);
      repeat (2) @(posedge clk);
      rdchk(`CDC_OFF_DAC_LEVEL, v & 32'h1f);
      chk(dacLevelCode, v[4:0]);
    end
    note("dac");
    for (c = 0; c < 2; c++) begin
      base = c ? `CDC_OFF_CMPA_2 : `CDC_OFF_CMPA_1;
      for (i = 0; i < 4; i++) begin
        p = i[1];
        r = i[0];
        want[c] <= r[0];
        bus(1'b1, base, 8'h82 | p << 4);
        repeat (12) @(posedge clk);
        e = r ^ p;
        rdchk(base, 8'h82 | p << 4 | e << 6);
        rdchk(`CDC_OFF_CMP_MIRROR, e << c);
        chk({cmpInputsOn, cmpHysteresis, cmpGate, cmpPinOut},
          {2'(1 << c), 2'(1 << c), 2'(e << c), 2'(e << c)});
      end
      want[c] <= 1'b1;
      bus(1'b1, base, 32'h0);
      repeat (12) @(posedge clk);
      rdchk(base, 0);
      chk({cmpInputsOn, cmpGate}, 0);
    end
    note("comparator");
    bus(1'b1, `CDC_OFF_CMPB_1, 32'h2);
    bus(1'b1, `CDC_OFF_CMPA_1, 32'h80);
    for (i = 0; i < 2; i++) begin
      want[0] <= i[0];
      repeat (12) @(posedge clk);
      irqFlagClear <= 1'b1;
      repeat (4) @(posedge clk);
      irqFlagClear <= 1'b0;
      repeat (4) @(posedge clk);
      chk(cmpIrqFlag, 0);
      want[0] <= ~i[0];
      repeat (12) @(posedge clk);
      chk(cmpIrqFlag, i == 0);
    end
    bus(1'b1, `CDC_OFF_CMPA_1, 32'h10);
    repeat (12) @(posedge clk);
    chk(cmpIrqFlag, 2'h1);
    bus(1'b1, `CDC_OFF_CMPA_1, 32'h91);
    repeat (30) @(posedge clk);
    chk(cmpGate, 2'h1);
    note("interrupt");
    repeat (40) begin
      pinRouteSel <= 2'($urandom);
      pinDirection <= 2'($urandom);
      repeat (3) @(posedge clk);
    end
    bus(1'b1, `CDC_OFF_DAC_CTRL, 32'ha0);
    bus(1'b1, `CDC_OFF_DAC_LEVEL, 32'h1f);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk(`CDC_OFF_DAC_LEVEL, 0);
    chk({dacEnable, dacPinDriveEnable, dacLevelCode}, 0);
    repeat (20) @(posedge clk);
    note("pins and reset");
    test_done;
  end
endmodule // testbench
bind cdc_comparator_dac_control cdc_chk u_chk (.clk(clk), .rst_n(rst_n),
  .dacEnable(dacEnable), .dacLevelCode(dacLevelCode),
  .dacPosSource(dacPosSource), .dacPinDriveEnable(dacPinDriveEnable),
  .refPinReadValue(refPinReadValue), .refPinDigitalOff(refPinDigitalOff),
  .refPinIn(refPinIn), .pinRouteSel(pinRouteSel),
  .pinDirection(pinDirection), .cmpPinOe(cmpPinOe));
